/* File: rb_timer.v */
// How it works
// - Trigger bit write starts one-shot, reads zero
// - Abort bit write stops one-shot, reads zero
// - Active flag shows one-shot running or waiting
// - Forced halt clears one-shot active flag
// - One-shot control only acts in modes 1x
// - Mode field bits 1:0 pick operating mode
// - Write target bit: both or reload only
// - Bit 7 cuts the count source off
// - Forced halt sets prescaler to all ones
// - Forced halt sets secondary to all ones
// - Forced halt sets primary to all ones
// - Secondary commits when primary is written
// - Waveform alternates reloads, primary reads live count
// - Delayed mode: primary waits, secondary pulse width
// - Timer mode reloads primary on underflow
// - Underflow every (n+1)(m+1) source cycles
// - Interrupt each underflow, pin is plain port
// - Run bit starts, clear or halt stops
// - Running writes reach counters on next event
// - Control: run, status, halt reads zero
//
// Chosen here: the Avalon-MM interface to the registers.
`include "rb_timer_defs.vh"
`default_nettype none
module rb_timer (
   input wire clk_sys,
   input wire nrst,
   input wire [11:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire companion_underflow,
   input wire external_trigger_input,
   input wire port_latch,
   output reg pulse_output_pin,
   output reg timer_irq
);
   // ==========================================
   // Declarations
   reg run_request_bit;
   reg run_status_flag;
   reg oneshot_active_flag;
   reg [3:0] out_ctl;
   reg [7:0] mode_cfg;
   reg [7:0] pre_rl;
   reg [7:0] pri_rl;
   reg [7:0] sec_rl;
   reg [7:0] sec_staged;
   reg phase;
   reg pre_pend;
   reg tmr_pend;
   reg [`SYNC_STAGES-1:0] trig_sync;
   reg trig_last;
   reg [7:0] rd_mux;
   wire take;
   wire wr;
   wire [9:0] idx;
   wire wr_ctrl;
   wire wr_osc;
   wire wr_ioc;
   wire wr_mode;
   wire wr_pre;
   wire wr_sec;
   wire wr_pri;
   wire halt;
   wire stopped;
   wire [1:0] op_mode;
   wire osc_en;
   wire alt_mode;
   wire write_target_select;
   wire src_tick;
   wire counting;
   wire tick;
   wire ext_level;
   wire ext_edge;
   wire sw_trig;
   wire abort;
   wire trig;
   wire os_end;
   wire restart;
   wire pre_load;
   wire pre_dec;
   wire [7:0] pre_val;
   wire [7:0] pre_cnt;
   wire pre_uf;
   wire tmr_load;
   wire tmr_dec;
   wire [7:0] tmr_val;
   wire [7:0] tmr_cnt;
   wire tmr_uf;
   wire pulse_phase;
   wire level;

   // ==========================================
   // Avalon-MM slave
   // A request is held one cycle with waitrequest high, then answered
   assign take = (read | write) & waitrequest;
   assign wr = write & ~waitrequest;
   assign idx = address[11:2];
   assign wr_ctrl = wr & (idx == `IDX_TIMER_CONTROL);
   assign wr_osc = wr & (idx == `IDX_ONESHOT_CONTROL);
   assign wr_ioc = wr & (idx == `IDX_OUTPUT_TRIGGER_CONTROL);
   assign wr_mode = wr & (idx == `IDX_TIMER_MODE_CONFIG);
   assign wr_pre = wr & (idx == `IDX_PRESCALER_COUNT);
   assign wr_sec = wr & (idx == `IDX_SECONDARY_RELOAD);
   assign wr_pri = wr & (idx == `IDX_PRIMARY_COUNT);

   // Wait state generator
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~take;
      end
   end

   // Read view; unmapped and write-only words read zero
   always @* begin
      case (idx)
         `IDX_TIMER_CONTROL: rd_mux = {6'h00, run_status_flag, run_request_bit};
         `IDX_ONESHOT_CONTROL: rd_mux = {5'h00, oneshot_active_flag, 2'h0};
         `IDX_OUTPUT_TRIGGER_CONTROL: rd_mux = {4'h0, out_ctl};
         `IDX_TIMER_MODE_CONFIG: rd_mux = mode_cfg;
         `IDX_PRESCALER_COUNT: rd_mux = pre_cnt;
         `IDX_PRIMARY_COUNT: rd_mux = tmr_cnt;
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data stand while waitrequest is low
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         readdata <= 32'h0000_0000;
      end else if (take && read) begin
         readdata <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================
   // Mode decode
   assign op_mode = mode_cfg[1:0];
   assign osc_en = op_mode[1];
   assign alt_mode = (op_mode == `OPMODE_WAVEFORM) | (op_mode == `OPMODE_DELAYED);
   assign write_target_select = mode_cfg[`MODE_WRITE_TARGET];
   assign halt = wr_ctrl & writedata[`CTL_FORCED_HALT];
   assign stopped = ~run_status_flag;

   // Configuration registers
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode_cfg <= `MODE_RESET;
         out_ctl <= `IOC_RESET;
      end else begin
         if (wr_mode) begin
            mode_cfg <= writedata[7:0] & `MODE_WRITE_MASK;
         end
         if (wr_ioc) begin
            out_ctl <= writedata[3:0];
         end
      end
   end

   // ==========================================
   // Count source
   rb_source_select u_src (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sel(mode_cfg[5:4]),
      .gate_off(mode_cfg[`MODE_GATE_OFF]),
      .companion_underflow(companion_underflow),
      .tick(src_tick)
   );

   // Run control; status follows the request one cycle later, but a forced halt clears both in the same cycle
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         run_request_bit <= 1'b0;
         run_status_flag <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            run_request_bit <= writedata[`CTL_RUN_REQUEST] & ~halt;
         end
         run_status_flag <= run_request_bit & ~halt;
      end
   end

   // One-shot modes count only while a shot is active
   assign counting = osc_en ? oneshot_active_flag : 1'b1;
   assign tick = run_status_flag & src_tick & counting;

   // ==========================================
   // External trigger, synchronised before any edge logic
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trig_sync <= {`SYNC_STAGES{1'b1}}; // Pin idles high, so no false edge after reset
         trig_last <= 1'b1;
      end else begin
         trig_sync <= {trig_sync[`SYNC_STAGES-2:0], external_trigger_input};
         trig_last <= ext_level;
      end
   end
   assign ext_level = trig_sync[`SYNC_STAGES-1];
   // Polarity 1 takes rising edges, 0 falling
   assign ext_edge = out_ctl[`IOC_EXT_POLARITY] ? (ext_level & ~trig_last) : (~ext_level & trig_last);

   // ==========================================
   // One-shot sequencing
   assign sw_trig = wr_osc & writedata[`OSC_TRIGGER] & osc_en;
   assign abort = wr_osc & writedata[`OSC_ABORT] & osc_en;
   // A trigger while a shot runs is ignored
   assign trig = run_status_flag & osc_en & ~oneshot_active_flag & ~abort
                 & (sw_trig | (ext_edge & out_ctl[`IOC_EXT_ENABLE]));
   // Delayed mode ends after the pulse phase, plain one-shot at once
   assign os_end = osc_en & oneshot_active_flag & tmr_uf
                   & ((op_mode == `OPMODE_ONESHOT) | phase);
   assign restart = trig | os_end | (abort & oneshot_active_flag);

   // Active flag and phase; primary phase first after every start
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         oneshot_active_flag <= 1'b0;
         phase <= 1'b0;
      end else if (halt || abort || !run_request_bit) begin
         oneshot_active_flag <= 1'b0;
         phase <= 1'b0;
      end else if (trig) begin
         oneshot_active_flag <= 1'b1;
         phase <= 1'b0;
      end else if (os_end) begin
         oneshot_active_flag <= 1'b0;
         phase <= 1'b0;
      end else if (tmr_uf && alt_mode) begin
         phase <= ~phase;
      end else if (!run_status_flag) begin
         phase <= 1'b0;
      end
   end

   // ==========================================
   // Reload registers
   // Secondary is staged and only commits with the primary write
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pre_rl <= `COUNT_RESET;
         pri_rl <= `COUNT_RESET;
         sec_rl <= `COUNT_RESET;
         sec_staged <= `COUNT_RESET;
      end else if (halt) begin
         pre_rl <= `COUNT_RESET;
         pri_rl <= `COUNT_RESET;
         sec_rl <= `COUNT_RESET;
         sec_staged <= `COUNT_RESET;
      end else begin
         if (wr_pre) begin
            pre_rl <= writedata[7:0];
         end
         if (wr_sec) begin
            sec_staged <= writedata[7:0];
         end
         if (wr_pri) begin
            pri_rl <= writedata[7:0];
            sec_rl <= sec_staged;
         end
      end
   end

   // Running writes with write-both wait for the counters' own event
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pre_pend <= 1'b0;
         tmr_pend <= 1'b0;
      end else if (halt || stopped) begin
         pre_pend <= 1'b0;
         tmr_pend <= 1'b0;
      end else begin
         if (wr_pre && !write_target_select) begin
            pre_pend <= 1'b1;
         end else if (tick) begin
            pre_pend <= 1'b0;
         end
         if (wr_pri && !write_target_select) begin
            tmr_pend <= 1'b1;
         end else if (pre_uf) begin
            tmr_pend <= 1'b0;
         end
      end
   end

   // ==========================================
   // Prescaler counter
   assign pre_load = halt | (wr_pre & stopped) | (tick & pre_pend) | restart;
   assign pre_dec = tick & ~pre_pend;
   assign pre_val = halt ? `COUNT_RESET : ((wr_pre & stopped) ? writedata[7:0] : pre_rl);

   rb_down_counter #(.W(8)) u_pre (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .load(pre_load),
      .dec(pre_dec),
      .value(pre_val),
      .count(pre_cnt),
      .underflow(pre_uf)
   );

   // ==========================================
   // Timer counter; counts prescaler underflows
   assign tmr_load = halt | (wr_pri & stopped) | (pre_uf & tmr_pend) | restart;
   assign tmr_dec = pre_uf & ~tmr_pend;
   // Leaving the primary phase reloads from the secondary value
   assign tmr_val = halt ? `COUNT_RESET :
                    (wr_pri & stopped) ? writedata[7:0] :
                    (tmr_uf & ~phase & alt_mode & ~os_end) ? sec_rl : pri_rl;

   rb_down_counter #(.W(8)) u_tmr (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .load(tmr_load),
      .dec(tmr_dec),
      .value(tmr_val),
      .count(tmr_cnt),
      .underflow(tmr_uf)
   );

   // ==========================================
   // Interrupt request pulse
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         timer_irq <= 1'b0;
      end else begin
         case (op_mode)
            `OPMODE_TIMER: timer_irq <= tmr_uf;
            `OPMODE_WAVEFORM: timer_irq <= tmr_uf & phase;
            default: timer_irq <= os_end;
         endcase
      end
   end

   // ==========================================
   // Pulse output pin
   // Level select 0 drives high in the primary or pulse phase
   assign pulse_phase = osc_en ? (oneshot_active_flag & ((op_mode == `OPMODE_ONESHOT) | phase))
                               : (run_status_flag & ~phase);
   assign level = pulse_phase ^ out_ctl[`IOC_LEVEL_SELECT];

   // Timer mode or output switch hands the pin to the port latch
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pulse_output_pin <= 1'b0;
      end else if ((op_mode == `OPMODE_TIMER) || out_ctl[`IOC_OUTPUT_SWITCH]) begin
         pulse_output_pin <= port_latch;
      end else begin
         pulse_output_pin <= level;
      end
   end
endmodule // rb_timer
`default_nettype wire

/* File: rb_timer_defs.vh */
`ifndef RB_TIMER_DEFS_VH
`define RB_TIMER_DEFS_VH
// ==========================================
// Register indexes (byte address = 4 x index)
`define IDX_TIMER_CONTROL 10'h108
`define IDX_ONESHOT_CONTROL 10'h109
`define IDX_OUTPUT_TRIGGER_CONTROL 10'h10a
`define IDX_TIMER_MODE_CONFIG 10'h10b
`define IDX_PRESCALER_COUNT 10'h10c
`define IDX_SECONDARY_RELOAD 10'h10d
`define IDX_PRIMARY_COUNT 10'h10e
// ==========================================
// Field positions
`define CTL_RUN_REQUEST 0
`define CTL_RUN_STATUS 1
`define CTL_FORCED_HALT 2
`define OSC_TRIGGER 0
`define OSC_ABORT 1
`define OSC_ACTIVE 2
`define IOC_LEVEL_SELECT 0
`define IOC_OUTPUT_SWITCH 1
`define IOC_EXT_ENABLE 2
`define IOC_EXT_POLARITY 3
`define MODE_WRITE_TARGET 3
`define MODE_GATE_OFF 7
// ==========================================
// Operating modes and count sources
`define OPMODE_TIMER 2'h0
`define OPMODE_WAVEFORM 2'h1
`define OPMODE_ONESHOT 2'h2
`define OPMODE_DELAYED 2'h3
`define SRC_F1 2'h0
`define SRC_F8 2'h1
`define SRC_COMPANION 2'h2
`define SRC_F2 2'h3
// ==========================================
// Reset values, masks and timing counts
`define COUNT_RESET 8'hff
`define MODE_RESET 8'h00
`define MODE_WRITE_MASK 8'hbb
`define IOC_RESET 4'h0
`define SYNC_STAGES 2
`endif

/* File: rb_down_counter.v */
`default_nettype none
// ==========================================
// Reloadable down counter
module rb_down_counter #(
   parameter W = 8
) (
   input wire clk_sys,
   input wire nrst,
   input wire load,
   input wire dec,
   input wire [W-1:0] value,
   output reg [W-1:0] count,
   output wire underflow
);
   // Passing below zero is the underflow; it reloads from value
   assign underflow = dec & (count == {W{1'b0}});

   // Load wins over decrement
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count <= {W{1'b1}};
      end else if (load || underflow) begin
         count <= value;
      end else if (dec) begin
         count <= count - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // rb_down_counter
`default_nettype wire

/* File: rb_source_select.v */
`include "rb_timer_defs.vh"
`default_nettype none
// ==========================================
// Count source enable pulses
module rb_source_select (
   input wire clk_sys,
   input wire nrst,
   input wire [1:0] sel,
   input wire gate_off,
   input wire companion_underflow,
   output reg tick
);
   reg [2:0] div;

   // Free running divider gives f2 and f8 as one-cycle enables
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div <= 3'h0;
      end else begin
         div <= div + 3'h1;
      end
   end

   // Gate off cuts the source before the prescaler
   always @* begin
      case (sel)
         `SRC_F1: tick = 1'b1;
         `SRC_F8: tick = (div == 3'h7);
         `SRC_COMPANION: tick = companion_underflow;
         `SRC_F2: tick = div[0];
         default: tick = 1'b0;
      endcase
      if (gate_off) begin
         tick = 1'b0;
      end
   end
endmodule // rb_source_select
`default_nettype wire

/* File: rb_timer_properties.sv */
`include "rb_timer_defs.vh"
`default_nettype none
// ==========================================
// Port-level checks on the prescaled reload timer
module rb_timer_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic companion_underflow,
   input wire logic external_trigger_input,
   input wire logic port_latch,
   input wire logic pulse_output_pin,
   input wire logic timer_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [9:0] idx = address[11:2];
   wire logic ans_rd = read && !waitrequest;
   logic [1:0] mode_sh;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow of the mode field, updated where a write lands
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         mode_sh <= `OPMODE_TIMER;
      else if (write && !waitrequest && idx == `IDX_TIMER_MODE_CONFIG)
         mode_sh <= writedata[1:0];
   end
   answer_next_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered in one cycle");
   wait_one_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   upper_zero_a: assert property (readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   halt_reads_zero_a: assert property (ans_rd && idx == `IDX_TIMER_CONTROL |-> !readdata[`CTL_FORCED_HALT])
      else $error("forced halt bit read back as one");
   osc_cmd_zero_a: assert property (ans_rd && idx == `IDX_ONESHOT_CONTROL |-> readdata[1:0] == 2'b00)
      else $error("one-shot command bits read back as one");
   osc_mode_gate_a: assert property (ans_rd && idx == `IDX_ONESHOT_CONTROL && !mode_sh[1] |-> !readdata[2])
      else $error("one-shot active outside one-shot modes");
   secondary_wo_a: assert property (ans_rd && idx == `IDX_SECONDARY_RELOAD |-> readdata == 32'h0000_0000)
      else $error("secondary reload readable");
   mode_reserved_a: assert property (ans_rd && idx == `IDX_TIMER_MODE_CONFIG |-> !readdata[2] && !readdata[6])
      else $error("mode reserved bits read as one");
   unmapped_zero_a: assert property (ans_rd && (idx < `IDX_TIMER_CONTROL || idx > `IDX_PRIMARY_COUNT)
      |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   // Registered pin follows the port latch; needs two cycles of timer mode out of reset
   timer_pin_port_a: assert property ($past(nrst) && mode_sh == `OPMODE_TIMER
      && $past(mode_sh) == `OPMODE_TIMER |-> pulse_output_pin == $past(port_latch))
      else $error("pin not the port latch in timer mode");
endmodule // rb_timer_checker

bind rb_timer rb_timer_checker rb_timer_checker_i (.clk_sys(clk_sys), .nrst(nrst), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .companion_underflow(companion_underflow), .external_trigger_input(external_trigger_input),
   .port_latch(port_latch), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));
`default_nettype wire

/* File: rb_timer_test.sv */
`include "rb_timer_defs.vh"
`default_nettype none
// ==========================================
// Self-checking bench for the prescaled reload timer
module rb_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic companion_underflow = 1'b0;
   logic external_trigger_input = 1'b1;
   logic port_latch = 1'b0;
   logic comp_en = 1'b0;
   wire [31:0] readdata;
   wire waitrequest;
   wire pulse_output_pin;
   wire timer_irq;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int cdiv = 0;
   int seed = 32'hca59;
   int n, m, p, src, q;
   logic [7:0] d;
   logic [7:0] rv [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
   rb_timer rb_timer_i (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .companion_underflow(companion_underflow), .external_trigger_input(external_trigger_input),
      .port_latch(port_latch), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));
   // 40 MHz clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Companion pulse every third cycle, latch toggles so the pin check bites
   always @(posedge clk_sys) begin
      cdiv <= (cdiv == 2) ? 0 : cdiv + 1;
      companion_underflow <= comp_en && cdiv == 0;
      port_latch <= ~port_latch;
   end
   // Hang guard, well above the longest expected run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ==========================================
   // Tasks
   task tally_and_finish;
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Avalon cycle: request held until waitrequest is sampled low
   // Only the hang guard ends a wait that never gets its answer
   task bus(input logic is_wr, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      address <= {idx, 2'b00};
      writedata <= 32'(wd);
      read <= !is_wr;
      write <= is_wr;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0)
         @(posedge clk_sys);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [31:0] x;
      bus(1'b1, idx, wd, x);
   endtask
   task rd_chk(input string nm, input logic [9:0] idx, input logic [7:0] e);
      logic [31:0] x;
      bus(1'b0, idx, 8'h00, x);
      chk(nm, 32'(e), x);
   endtask
   // Halt first so mode changes happen stopped; negative sec leaves secondary at the halt value of all ones
   task setup(input logic [7:0] md, input logic [7:0] pre, input int sec, input logic [7:0] pri);
      wr(`IDX_TIMER_CONTROL, 8'h04);
      wr(`IDX_TIMER_MODE_CONFIG, md);
      wr(`IDX_PRESCALER_COUNT, pre);
      if (sec >= 0)
         wr(`IDX_SECONDARY_RELOAD, 8'(sec));
      wr(`IDX_PRIMARY_COUNT, pri);
      wr(`IDX_TIMER_CONTROL, 8'h01);
   endtask
   // Cycles between two interrupt pulses; zero if none comes
   task period(output int pr);
      int k;
      k = 0;
      pr = 0;
      while (timer_irq !== 1'b1 && k < 2000) begin
         @(posedge clk_sys);
         k++;
      end
      if (k < 2000) begin
         pr = 1;
         @(posedge clk_sys);
         while (timer_irq !== 1'b1 && pr < 2000) begin
            @(posedge clk_sys);
            pr++;
         end
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
         rd_chk("reset value", 10'(10'h108 + i), rv[i]);
      // Field storage with random data while stopped
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         wr(`IDX_TIMER_MODE_CONFIG, d);
         rd_chk("mode", `IDX_TIMER_MODE_CONFIG, d & `MODE_WRITE_MASK);
         d = 8'($random(seed));
         wr(`IDX_OUTPUT_TRIGGER_CONTROL, d);
         rd_chk("io control", `IDX_OUTPUT_TRIGGER_CONTROL, d & 8'h0f);
      end
      wr(`IDX_OUTPUT_TRIGGER_CONTROL, 8'h00);
      // Timer mode period for every count source
      for (src = 0; src < 4; src++) begin
         n = $random(seed) & 3;
         m = ($random(seed) & 3) + 1;
         comp_en <= (src == 2);
         setup(8'(src << 4), 8'(n), -1, 8'(m));
         rd_chk("run status", `IDX_TIMER_CONTROL, 8'h03);
         period(p);
         q = (src == 0) ? 1 : (src == 1) ? 8 : (src == 2) ? 3 : 2;
         chk("timer period", q * (n + 1) * (m + 1), p);
      end
      wr(`IDX_TIMER_CONTROL, 8'h04);
      rd_chk("halted control", `IDX_TIMER_CONTROL, 8'h00);
      rd_chk("halted prescaler", `IDX_PRESCALER_COUNT, 8'hff);
      rd_chk("halted primary", `IDX_PRIMARY_COUNT, 8'hff);
      period(p);
      chk("irq after halt", 0, p);
      setup(8'h80, 8'h00, -1, 8'h02);
      period(p);
      chk("gated period", 0, p);
      // Running write-both writes wait for a tick (prescaler) or a prescaler underflow (primary); companion source held quiet
      comp_en <= 1'b0;
      setup(8'h20, 8'h10, -1, 8'h20);
      wr(`IDX_PRESCALER_COUNT, 8'h05);
      wr(`IDX_PRIMARY_COUNT, 8'h06);
      rd_chk("pending prescaler", `IDX_PRESCALER_COUNT, 8'h10);
      rd_chk("pending primary", `IDX_PRIMARY_COUNT, 8'h20);
      comp_en <= 1'b1;
      period(p);
      chk("written period", 3 * 6 * 7, p);
      // Waveform mode, write target kept at reload only
      setup(8'h09, 8'(n), 3, 8'(m));
      period(p);
      chk("waveform period", (n + 1) * (m + 5), p);
      setup(8'h09, 8'h00, -1, 8'h00);
      period(p);
      chk("halted secondary", 257, p);
      // One-shot trigger, abort and halt
      setup(8'h0a, 8'h00, -1, 8'hc8);
      wr(`IDX_ONESHOT_CONTROL, 8'h01);
      rd_chk("shot active", `IDX_ONESHOT_CONTROL, 8'h04);
      chk("shot pin", 1, pulse_output_pin);
      wr(`IDX_ONESHOT_CONTROL, 8'h02);
      rd_chk("shot aborted", `IDX_ONESHOT_CONTROL, 8'h00);
      wr(`IDX_ONESHOT_CONTROL, 8'h01);
      wr(`IDX_TIMER_CONTROL, 8'h04);
      rd_chk("shot halted", `IDX_ONESHOT_CONTROL, 8'h00);
      setup(8'h0a, 8'h00, -1, 8'h04);
      wr(`IDX_ONESHOT_CONTROL, 8'h01);
      repeat (12) @(posedge clk_sys);
      rd_chk("shot ended", `IDX_ONESHOT_CONTROL, 8'h00);
      // Falling edge on the trigger pin starts a short shot
      wr(`IDX_OUTPUT_TRIGGER_CONTROL, 8'h04);
      external_trigger_input <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk("pin trigger", `IDX_ONESHOT_CONTROL, 8'h04);
      external_trigger_input <= 1'b1;
      wr(`IDX_OUTPUT_TRIGGER_CONTROL, 8'h00);
      setup(8'h0b, 8'h00, 50, 8'h32);
      wr(`IDX_ONESHOT_CONTROL, 8'h01);
      rd_chk("delayed wait", `IDX_ONESHOT_CONTROL, 8'h04);
      chk("wait pin", 0, pulse_output_pin);
      setup(8'h00, 8'h00, -1, 8'hc8);
      wr(`IDX_ONESHOT_CONTROL, 8'h01);
      rd_chk("timer mode shot", `IDX_ONESHOT_CONTROL, 8'h00);
      tally_and_finish();
   end
endmodule // rb_timer_test
`default_nettype wire
